// ==== rtl/upfp_defs.svh ====
// Constants for the parallel FIFO port: offsets, fields, sizes and timing counts
`ifndef UPFP_DEFS_SVH
`define UPFP_DEFS_SVH
`define UPFP_CLK_MHZ        250
`define UPFP_RX_DEPTH       128
`define UPFP_TX_DEPTH       384
`define UPFP_RG_TIME_US     5000
`define UPFP_RG_CYCLES      (`UPFP_RG_TIME_US * `UPFP_CLK_MHZ)
`define UPFP_OSC_MHZ        6
`define UPFP_OSC_HALF       (`UPFP_CLK_MHZ / (2 * `UPFP_OSC_MHZ))
`define UPFP_REG_CTRL       8'h00
`define UPFP_REG_STATUS     8'h04
`define UPFP_REG_RX_PUSH    8'h08
`define UPFP_REG_TX_POP     8'h0c
`define UPFP_REG_EVENT      8'h10
`define UPFP_REG_IDENT      8'h14
`define UPFP_CTRL_CONFIG    0
`define UPFP_CTRL_SUSPEND   1
`define UPFP_CTRL_WAKE_EN   2
`define UPFP_EVT_RESUME     0
`define UPFP_EVT_FLUSH      1
`define UPFP_ST_CLK48       28
`define UPFP_ST_ALT_PID     29
`define UPFP_ST_TEST        30
`define UPFP_ST_POWER_N     31
`define UPFP_PID_NORMAL     16'h1234
`define UPFP_PID_ALT        16'h1235
`define UPFP_RESP_OKAY      2'b00
`define UPFP_RESP_SLVERR    2'b10
`endif

// ==== rtl/upfp_pkg.sv ====
// Types shared by the parallel FIFO port
package upfp_pkg;
  // Two-field form (value and output enable) of a two-way or open-drain pin driven by the block
  typedef struct packed {
    logic [7:0] data;
    logic       oe;
  } upfp_bus_t;
  typedef struct packed {
    logic level;
    logic oe;
  } upfp_od_t;
  // Reset generator output phases
  typedef enum logic [1:0] {
    RG_HIZ,
    RG_LOW,
    RG_HIGH
  } upfp_rg_t;
endpackage

// ==== rtl/upfp_port.sv ====
// Parallel FIFO port with receive and transmit buffers, power and reset control
`timescale 1ns/10ps
`default_nettype none
`include "upfp_defs.svh"

// Notes on behaviour
// [R1] Data bus driven with the current receive byte only while read strobe is low.
// [R2] Read strobe rising edge advances to the next receive byte if any.
// [R3] Write strobe falling edge captures the bus byte into the transmit buffer.
// [R4] Transmit-space flag high when no room; outside logic writes only when low.
// [R5] Receive-available flag low only with data; outside logic reads only then.
// [R6] Power enable low once configured, high while suspended.
// [R7] Suspended with wake enabled: low pulse on flush/wake raises a resume request.
// [R8] Not suspended: low pulse on flush/wake flushes the transmit buffer next bulk-IN; here it only sets the flush event bit for software.
// [R9] External reset low resets the block and drives the reset output low; the control register and AXI side keep their state.
// [R10] Reset output stays undriven about 5 ms after start, then drives high.
// [R11] A USB bus reset never touches the reset output.
// [R12] Select strap low chooses 48 MHz mode, unpulled chooses 6 MHz mode.
// [R13] Memory clock strap low reports the alternate product identifier.
// [R14] Oscillator output stops toggling while suspended.
// [R15] Test input must be low for normal use; high enters test mode.
// [R16] Receive buffer holds up to 128 bytes.
// [R17] Transmit buffer holds up to 384 bytes.
// [R18] Outside logic synchronises the two status flags before use.
module upfp_port #(
  parameter int unsigned RG_CYCLES = `UPFP_RG_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        data_i,
  output upfp_pkg::upfp_bus_t    data_out,
  input  wire logic              rd_n,
  input  wire logic              wr,
  output logic                   tx_space_n,
  output logic                   rx_avail_n,
  output logic                   bus_power_on_n,
  input  wire logic              flush_or_wake_n,
  input  wire logic              ext_reset_n,
  output upfp_pkg::upfp_od_t     reset_generator_out_n,
  input  wire logic              cfg_mem_select,
  input  wire logic              cfg_mem_clock,
  output logic                   osc_out,
  input  wire logic              test_mode
);
  import upfp_pkg::*;

  localparam int unsigned RXD = `UPFP_RX_DEPTH;
  localparam int unsigned TXD = `UPFP_TX_DEPTH;

  // Pin synchronisers, second stage and one more for edge detection
  logic [7:0] dat_s1_r, dat_s2_r;
  logic [5:0] pin_s1_r, pin_s2_r, pin_d_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dat_s1_r <= 8'h00;
      dat_s2_r <= 8'h00;
      pin_s1_r <= 6'h0f; // Idle levels, so no false edge follows reset
      pin_s2_r <= 6'h0f;
      pin_d_r  <= 6'h0f;
    end else begin
      dat_s1_r <= data_i;
      dat_s2_r <= dat_s1_r;
      pin_s1_r <= {test_mode, wr, rd_n, flush_or_wake_n, ext_reset_n, cfg_mem_select};
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end
  // Order: 5 test, 4 wr, 3 rd_n, 2 flush/wake, 1 ext reset, 0 select strap
  logic test_s, rd_s, ext_low, rd_rise, wr_fall, fw_fall, dev_rst;
  assign test_s  = pin_s2_r[5];
  assign rd_s    = pin_s2_r[3];
  assign ext_low = !pin_s2_r[1];
  assign rd_rise = pin_s2_r[3] && !pin_d_r[3];
  assign wr_fall = !pin_s2_r[4] && pin_d_r[4];
  assign fw_fall = !pin_s2_r[2] && pin_d_r[2];
  assign dev_rst = !aresetn || ext_low; // see [R9]

  // Software-side control standing in for the USB engine
  logic configured_r, suspended_r, wake_en_r;
  logic resume_r, flush_r;
  logic clk48_r, alt_pid_r, cfg_clk_s1_r, cfg_clk_s2_r, sel_s1_r, sel_s2_r;

  // Receive buffer, filled by software, drained by the read strobe
  logic [7:0] rx_mem_r [RXD];
  logic [6:0] rx_wp_r, rx_rp_r;
  logic [7:0] rx_cnt_r;
  logic       rx_push, rx_pop;
  assign rx_pop = rd_rise && (rx_cnt_r != 8'd0) && !test_s; // see [R2]
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      rx_wp_r  <= 7'd0;
      rx_rp_r  <= 7'd0;
      rx_cnt_r <= 8'd0;
    end else begin
      if (rx_push) begin
        rx_mem_r[rx_wp_r] <= w_data_r[7:0];
        rx_wp_r <= rx_wp_r + 7'd1; // Power of two depth wraps by itself, see [R16]
      end
      if (rx_pop)
        rx_rp_r <= rx_rp_r + 7'd1;
      rx_cnt_r <= rx_cnt_r + {7'd0, rx_push} - {7'd0, rx_pop};
    end
  end

  // Transmit buffer, filled by the write strobe, drained by software
  logic [7:0] tx_mem_r [TXD];
  logic [8:0] tx_wp_r, tx_rp_r, tx_cnt_r;
  logic       tx_push, tx_pop;
  assign tx_push = wr_fall && (tx_cnt_r != 9'(TXD)) && !test_s; // see [R3]
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      tx_wp_r  <= 9'd0;
      tx_rp_r  <= 9'd0;
      tx_cnt_r <= 9'd0;
    end else begin
      if (tx_push) begin
        tx_mem_r[tx_wp_r] <= dat_s2_r;
        tx_wp_r <= (tx_wp_r == 9'(TXD - 1)) ? 9'd0 : tx_wp_r + 9'd1; // see [R17]
      end
      if (tx_pop)
        tx_rp_r <= (tx_rp_r == 9'(TXD - 1)) ? 9'd0 : tx_rp_r + 9'd1;
      tx_cnt_r <= tx_cnt_r + {8'd0, tx_push} - {8'd0, tx_pop};
    end
  end

  // FIFO pins; flags held inactive during reset and test mode
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      data_out   <= '0;
      tx_space_n <= 1'b1;
      rx_avail_n <= 1'b1;
    end else begin
      data_out.oe   <= !rd_s && !test_s; // see [R1]
      data_out.data <= rx_mem_r[rx_rp_r];
      tx_space_n    <= test_s || (tx_cnt_r + {8'd0, tx_push} >= 9'(TXD)); // see [R4]
      rx_avail_n    <= test_s || (rx_cnt_r - {7'd0, rx_pop} == 8'd0); // see [R5]
    end
  end

  // Power enable follows configuration and suspend
  always_ff @(posedge aclk) begin
    if (dev_rst)
      bus_power_on_n <= 1'b1;
    else
      bus_power_on_n <= !configured_r || suspended_r; // see [R6]
  end

  // Straps caught while reset is held; own unreset synchronisers, since the
  // shared pin stages sit at their reset value for the whole reset
  always_ff @(posedge aclk) begin
    cfg_clk_s1_r <= cfg_mem_clock;
    cfg_clk_s2_r <= cfg_clk_s1_r;
    sel_s1_r     <= cfg_mem_select;
    sel_s2_r     <= sel_s1_r;
    if (dev_rst) begin
      clk48_r   <= !sel_s2_r; // see [R12]
      alt_pid_r <= !cfg_clk_s2_r; // see [R13]
    end
  end

  // Oscillator copy, a free divider that freezes in suspend
  logic [4:0] osc_cnt_r;
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      osc_cnt_r <= 5'd0;
      osc_out   <= 1'b0;
    end else if (!suspended_r) begin // see [R14]
      if (osc_cnt_r == 5'(`UPFP_OSC_HALF - 1)) begin
        osc_cnt_r <= 5'd0;
        osc_out   <= !osc_out;
      end else begin
        osc_cnt_r <= osc_cnt_r + 5'd1;
      end
    end
  end

  // Reset generator; only power-on and the external reset reach it, see [R11]
  upfp_rg_t   rg_r;
  logic [20:0] rg_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rg_r     <= RG_HIZ;
      rg_cnt_r <= 21'd0;
    end else if (ext_low) begin
      rg_r     <= RG_LOW; // see [R9]
      rg_cnt_r <= 21'd0;
    end else if (rg_r != RG_HIGH) begin
      if (rg_cnt_r == 21'(RG_CYCLES - 1))
        rg_r <= RG_HIGH; // see [R10]
      else
        rg_cnt_r <= rg_cnt_r + 21'd1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_generator_out_n <= '0;
    end else begin
      unique case (rg_r)
        RG_HIZ:  reset_generator_out_n <= '{level: 1'b0, oe: 1'b0};
        RG_LOW:  reset_generator_out_n <= '{level: 1'b0, oe: 1'b1};
        RG_HIGH: reset_generator_out_n <= '{level: 1'b1, oe: 1'b1};
        default: reset_generator_out_n <= '{level: 1'b0, oe: 1'b1};
      endcase
    end
  end

  // AXI4-Lite write: address and data in either order, response after both
  logic [7:0] aw_addr_r;
  logic       aw_have_r, w_have_r;
  logic [31:0] w_data_r;
  logic       wr_go;
  assign wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rx_push = wr_go && (aw_addr_r == `UPFP_REG_RX_PUSH) && (rx_cnt_r != 8'(RXD))
                   && !dev_rst;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UPFP_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_r)
          `UPFP_REG_CTRL, `UPFP_REG_EVENT:
            s_axi_bresp <= `UPFP_RESP_OKAY;
          `UPFP_REG_RX_PUSH:
            s_axi_bresp <= rx_push ? `UPFP_RESP_OKAY : `UPFP_RESP_SLVERR;
          default:
            s_axi_bresp <= `UPFP_RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic ctrl_wr, evt_wr;
  assign ctrl_wr = wr_go && (aw_addr_r == `UPFP_REG_CTRL);
  assign evt_wr  = wr_go && (aw_addr_r == `UPFP_REG_EVENT);

  // Control register; low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      configured_r <= 1'b0;
      suspended_r  <= 1'b0;
      wake_en_r    <= 1'b0;
    end else if (ctrl_wr) begin
      configured_r <= w_data_r[`UPFP_CTRL_CONFIG];
      suspended_r  <= w_data_r[`UPFP_CTRL_SUSPEND];
      wake_en_r    <= w_data_r[`UPFP_CTRL_WAKE_EN];
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      resume_r <= 1'b0;
      flush_r  <= 1'b0;
    end else begin
      if (fw_fall && suspended_r && wake_en_r)
        resume_r <= 1'b1; // see [R7]
      else if (evt_wr && w_data_r[`UPFP_EVT_RESUME])
        resume_r <= 1'b0;
      if (fw_fall && !suspended_r)
        flush_r <= 1'b1; // see [R8]
      else if (evt_wr && w_data_r[`UPFP_EVT_FLUSH])
        flush_r <= 1'b0;
    end
  end

  // AXI4-Lite read: one-cycle answer; the pop register drains the transmit buffer
  logic ar_hs;
  assign ar_hs  = s_axi_arvalid && s_axi_arready;
  assign tx_pop = ar_hs && (s_axi_araddr == `UPFP_REG_TX_POP) && (tx_cnt_r != 9'd0)
                  && !dev_rst;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `UPFP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_hs;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `UPFP_RESP_OKAY;
        unique case (s_axi_araddr)
          `UPFP_REG_CTRL:
            s_axi_rdata <= {29'h0, wake_en_r, suspended_r, configured_r};
          `UPFP_REG_STATUS:
            s_axi_rdata <= {bus_power_on_n, test_s, alt_pid_r, clk48_r, 3'h0,
                            tx_cnt_r, 8'h00, rx_cnt_r};
          `UPFP_REG_TX_POP:
            s_axi_rdata <= {23'h0, tx_pop, tx_pop ? tx_mem_r[tx_rp_r] : 8'h00};
          `UPFP_REG_EVENT:
            s_axi_rdata <= {30'h0, flush_r, resume_r};
          `UPFP_REG_IDENT: // Identifier values are arbitrary
            s_axi_rdata <= {16'h0, alt_pid_r ? `UPFP_PID_ALT : `UPFP_PID_NORMAL};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `UPFP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (dev_rst);
  bus_drive_a: assert property (!rd_s && !test_s |=> data_out.oe) // see [R1]
    else $error("data bus not driven during read");
  bus_release_a: assert property (rd_s |=> !data_out.oe) // see [R1]
    else $error("data bus driven outside read");
  rx_advance_a: assert property (rx_pop |=> rx_rp_r == $past(rx_rp_r) + 7'd1) // see [R2]
    else $error("receive pointer did not advance");
  tx_capture_a: assert property (tx_push |=> tx_mem_r[$past(tx_wp_r)] == $past(dat_s2_r))
    else $error("write byte not captured"); // see [R3]
  tx_full_a: assert property (tx_cnt_r == 9'(TXD) |-> tx_space_n) // see [R4]
    else $error("space flag low while full");
  rx_empty_a: assert property (rx_cnt_r == 8'd0 |-> rx_avail_n) // see [R5]
    else $error("available flag low while empty");
  power_en_a: assert property (suspended_r |=> bus_power_on_n) // see [R6]
    else $error("power enable low in suspend");
  resume_set_a: assert property (fw_fall && suspended_r && wake_en_r |=> resume_r)
    else $error("resume request lost"); // see [R7]
  flush_set_a: assert property (fw_fall && !suspended_r |=> flush_r) // see [R8]
    else $error("flush request lost");
  osc_stop_a: assert property (suspended_r && $past(suspended_r) |-> $stable(osc_out))
    else $error("oscillator toggles in suspend"); // see [R14]
  rst_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_low ##1 ext_low ##1 ext_low |-> reset_generator_out_n == '{level: 1'b0, oe: 1'b1})
    else $error("reset output not low under external reset"); // see [R9]
  read_cycle_c: cover property (!rd_s ##[1:20] rx_pop);
  write_cycle_c: cover property (tx_push ##[1:50] tx_pop);
  wake_c: cover property (fw_fall && suspended_r && wake_en_r);
  rg_high_c: cover property (rg_r == RG_HIGH);
endmodule
`default_nettype wire

// ==== tb/upfp_host_model.sv ====
// Model of the outside logic that drives the FIFO strobes and data bus
`timescale 1ns/10ps
`default_nettype none
module upfp_host_model (
  input  wire logic       aclk,
  input  wire logic [7:0] bus_in,
  input  wire logic       tx_space_n,
  input  wire logic       rx_avail_n,
  output logic            rd_n,
  output logic            wr,
  output logic [7:0]      drv,
  output logic            drv_oe
);
  logic [1:0] txs_r;
  logic [1:0] rxa_r;
  // Flags change off our clock, so resample them before acting
  always @(posedge aclk) begin
    txs_r <= {txs_r[0], tx_space_n};
    rxa_r <= {rxa_r[0], rx_avail_n};
  end
  initial begin
    rd_n = 1'b1;
    wr = 1'b0;
    drv = 8'h00;
    drv_oe = 1'b0;
  end
  // One read strobe; refused while the flag says empty
  task automatic read_byte(output logic [7:0] b, output logic ok);
    ok = (rxa_r[1] === 1'b0);
    b = 8'h00;
    if (ok) begin
      rd_n <= 1'b0;
      repeat (5) @(posedge aclk);
      b = bus_in;
      rd_n <= 1'b1;
      repeat (8) @(posedge aclk); // Flag settles through our resampler
    end
  endtask
  // One write strobe, high then low; refused while there is no room
  task automatic write_byte(input logic [7:0] b, output logic ok);
    ok = (txs_r[1] === 1'b0);
    if (ok) begin
      drv <= b;
      drv_oe <= 1'b1;
      wr <= 1'b1;
      repeat (5) @(posedge aclk);
      wr <= 1'b0;
      repeat (5) @(posedge aclk);
      drv_oe <= 1'b0; // Bus released; the pull-up takes it high
      repeat (5) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the parallel FIFO port
`timescale 1ns/10ps
`default_nettype none
`include "upfp_defs.svh"
module tb_top;
  import upfp_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, drv;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  upfp_bus_t   data_out;
  upfp_od_t    rgo;
  wire logic [7:0] data_i;
  logic        rd_n, wr, tx_space_n, rx_avail_n, pwr_n, fw_n, ext_n;
  logic        cfg_sel, cfg_clk, osc_out, drv_oe, ok;
  logic [7:0]  b;
  int          n_errors, num_checks, cyc, i, n, k;
  logic [2:0]  ctl [3] = '{3'h1, 3'h7, 3'h3};
  logic [1:0]  evx [3] = '{2'h2, 2'h1, 2'h0};
  // Shared data pins: the port, then the host, else the pull-up
  assign data_i = data_out.oe ? data_out.data : (drv_oe ? drv : 8'hff);
  upfp_port #(.RG_CYCLES(50)) upfp_port_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .data_i(data_i), .data_out(data_out), .rd_n(rd_n), .wr(wr), .tx_space_n(tx_space_n),
    .rx_avail_n(rx_avail_n), .bus_power_on_n(pwr_n), .flush_or_wake_n(fw_n),
    .ext_reset_n(ext_n), .reset_generator_out_n(rgo), .cfg_mem_select(cfg_sel),
    .cfg_mem_clock(cfg_clk), .osc_out(osc_out), .test_mode(1'b0));
  upfp_host_model upfp_host_model_inst (
    .aclk(aclk), .bus_in(data_i), .tx_space_n(tx_space_n), .rx_avail_n(rx_avail_n),
    .rd_n(rd_n), .wr(wr), .drv(drv), .drv_oe(drv_oe));
  always #2 aclk = ~aclk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // A hang ends the run as a mismatch
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Toggles seen on the oscillator output over 100 cycles
  task automatic osc_count(output int c);
    logic p;
    c = 0;
    p = osc_out;
    repeat (100) begin
      @(posedge aclk);
      if (osc_out !== p) c++;
      p = osc_out;
    end
  endtask
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {fw_n, ext_n, cfg_sel, cfg_clk} = 4'hc; // Straps low: 48 MHz, other product id
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("rg_out", 2'b00, rgo);
    chk("power_n", 1, pwr_n);
    repeat (60) @(posedge aclk);
    chk("rg_out", 2'b11, rgo);
    axi_rd(`UPFP_REG_STATUS, rd, rs);
    chk("clk48", 1, rd[`UPFP_ST_CLK48]);
    axi_rd(`UPFP_REG_IDENT, rd, rs);
    chk("ident", `UPFP_PID_ALT, rd[15:0]);
    axi_rd(8'h18, rd, rs);
    chk("unmapped", `UPFP_RESP_SLVERR, rs);
    $display("test reset_straps done");
    // Fill the receive side to the brim, then drain it through the pins
    for (i = 0; i < 129; i++) begin
      axi_wr(`UPFP_REG_RX_PUSH, i, rs);
    end
    chk("rx_full", `UPFP_RESP_SLVERR, rs);
    chk("rx_avail_n", 0, rx_avail_n);
    for (i = 0; i < 128; i++) begin
      upfp_host_model_inst.read_byte(b, ok);
      chk("rx_byte", i[7:0], b);
    end
    upfp_host_model_inst.read_byte(b, ok);
    chk("rx_empty", 0, ok);
    $display("test rx_path done");
    // Write until the port refuses, then pop everything back
    n = 0;
    ok = 1'b1;
    while (ok) begin
      upfp_host_model_inst.write_byte(n[7:0] ^ 8'h3c, ok);
      if (ok) n++;
    end
    chk("tx_count", 384, n);
    chk("tx_space_n", 1, tx_space_n);
    axi_rd(`UPFP_REG_STATUS, rd, rs);
    chk("tx_level", 384, rd[24:16]);
    for (i = 0; i < 385; i++) begin
      axi_rd(`UPFP_REG_TX_POP, rd, rs);
      chk("tx_pop", i < 384 ? {1'b1, i[7:0] ^ 8'h3c} : 9'h000, rd[8:0]);
    end
    $display("test tx_path done");
    // Configured, suspended with and without wake: power, clock, events
    for (k = 0; k < 3; k++) begin
      axi_wr(`UPFP_REG_CTRL, ctl[k], rs);
      axi_rd(`UPFP_REG_CTRL, rd, rs);
      chk("ctrl", ctl[k], rd[2:0]);
      chk("power_n", ctl[k][1], pwr_n);
      osc_count(n);
      chk("osc_runs", !ctl[k][1], n > 0);
      fw_n <= 1'b0;
      repeat (5) @(posedge aclk);
      fw_n <= 1'b1;
      repeat (5) @(posedge aclk);
      axi_rd(`UPFP_REG_EVENT, rd, rs);
      chk("event", evx[k], rd[1:0]);
      axi_wr(`UPFP_REG_EVENT, 3, rs);
    end
    $display("test power_events done");
    // Outside reset drops the reset output and empties the buffers
    axi_wr(`UPFP_REG_RX_PUSH, 8'h5a, rs);
    ext_n <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("rg_out", 2'b01, rgo);
    chk("rx_avail_n", 1, rx_avail_n);
    ext_n <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("rg_out", 2'b01, rgo);
    repeat (50) @(posedge aclk);
    chk("rg_out", 2'b11, rgo);
    $display("test ext_reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
